/* iog_fn_decode.sv */
`timescale 1ns/1ps
module iog_fn_decode #(
    parameter int CODE_W = 4
) (
    // clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     rst_n_i,
    // code and strobe
    input  wire logic [CODE_W-1:0]        code_i,
    input  wire logic                     strobe_n_i,
    input  wire logic                     enable_i,
    // one-hot pulses
    output logic      [(1<<CODE_W)-1:0]   pulse_o
);
    function automatic logic [(1<<CODE_W)-1:0] onehot(input logic [CODE_W-1:0] c);
        onehot    = '0;
        onehot[c] = 1'b1;
    endfunction

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pulse_o <= '0;
        end else if (!strobe_n_i && enable_i) begin
            pulse_o <= onehot(code_i);
        end else begin
            pulse_o <= '0;
        end
    end
endmodule

/* iog_glue.sv */
`timescale 1ns/1ps
module iog_glue (
    // clock and reset
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    // apb slave
    input  wire logic [7:0]    paddr_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [31:0]   pwdata_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    output logic               irq_o,
    // controller side
    input  wire logic [3:0]    function_code_i,
    input  wire logic          function_code_valid_n_i,
    input  wire logic          ctl_busy_i,
    input  wire logic          ctl_done_i,
    output logic               busy_set_n_o,
    output logic               done_set_n_o,
    output logic               irq_ack_enable_o,
    output logic               channel_ack_enable_o,
    output logic               clock_phase_one_o,
    output logic               clock_phase_two_o,
    // io bus request drivers, open collector
    output logic               bus_irq_request_oe_o,
    output logic               bus_channel_request_oe_o,
    // peripheral side
    input  wire logic          set_busy_i,
    input  wire logic          set_done_i,
    output logic               busy_o,
    output logic               done_o,
    input  wire logic          irq_request_sync_n_i,
    input  wire logic          channel_request_sync_n_i,
    output logic [15:0]        control_pulse_o,
    input  wire logic [15:0]   data_i,
    output logic [15:0]        data_o,
    output logic [15:0]        data_oe_o,
    // priority chains
    input  wire logic          irq_priority_chain_in_i,
    output logic               irq_priority_chain_out_o,
    input  wire logic          channel_priority_chain_in_i,
    output logic               channel_priority_chain_out_o
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int SYN_W = 13;
    // idle pin levels: chains granted, no request, strobe high, flags clear
    localparam logic [SYN_W-1:0] SYN_RST = 13'h1f00;
    logic [SYN_W-1:0] syn1_reg;
    logic [SYN_W-1:0] syn2_reg;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            syn1_reg <= SYN_RST;
            syn2_reg <= SYN_RST;
        end else begin
            syn1_reg <= {irq_priority_chain_in_i, channel_priority_chain_in_i,
                         irq_request_sync_n_i, channel_request_sync_n_i,
                         function_code_valid_n_i, function_code_i,
                         ctl_busy_i, ctl_done_i, set_busy_i, set_done_i};
            syn2_reg <= syn1_reg;
        end
    end

    // chains and acks lag the pins by the two synchroniser stages
    logic       irq_chain_in;
    logic       ch_chain_in;
    logic       irq_req;
    logic       ch_req;
    logic       strobe_n;
    logic [3:0] fcode;
    logic       flag_busy;
    logic       flag_done;
    logic       req_busy;
    logic       req_done;
    assign irq_chain_in = syn2_reg[12];
    assign ch_chain_in  = syn2_reg[11];
    assign irq_req      = ~syn2_reg[10];
    assign ch_req       = ~syn2_reg[9];
    assign strobe_n     = syn2_reg[8];
    assign fcode        = syn2_reg[7:4];
    assign flag_busy    = syn2_reg[3];
    assign flag_done    = syn2_reg[2];
    assign req_busy     = syn2_reg[1];
    assign req_done     = syn2_reg[0];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    localparam int EV_W = iog_pkg::EV_W;
    logic [7:0]      code_reg;
    logic [3:0]      mbit_reg;
    logic            dec_en_reg;
    logic [3:0]      evmask_reg;
    logic [EV_W-1:0] event_reg;
    logic [EV_W-1:0] event_next;
    logic            wr_en;
    logic            rd_en;
    logic            hit;

    assign wr_en     = psel_i && penable_i && pwrite_i;
    assign rd_en     = psel_i && penable_i && !pwrite_i;
    assign hit       = (paddr_i == iog_pkg::CFG_OFFS) || (paddr_i == iog_pkg::STAT_OFFS)
                    || (paddr_i == iog_pkg::EVT_OFFS) || (paddr_i == iog_pkg::EVMASK_OFFS);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_reg   <= iog_pkg::CODE_RST;
            mbit_reg   <= iog_pkg::MBIT_RST;
            dec_en_reg <= iog_pkg::DEC_EN_RST;
            evmask_reg <= iog_pkg::EVMASK_RST;
        end else if (wr_en && paddr_i == iog_pkg::CFG_OFFS) begin
            code_reg   <= pwdata_i[iog_pkg::CFG_CODE_LSB +: 8];
            mbit_reg   <= pwdata_i[iog_pkg::CFG_MBIT_LSB +: 4];
            dec_en_reg <= pwdata_i[iog_pkg::CFG_DEC_EN];
        end else if (wr_en && paddr_i == iog_pkg::EVMASK_OFFS) begin
            evmask_reg <= pwdata_i[EV_W-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                iog_pkg::CFG_OFFS:    prdata_o <= {19'h0, dec_en_reg, mbit_reg, code_reg};
                iog_pkg::STAT_OFFS:   prdata_o <= {22'h0, fcode, ch_chain_in, irq_chain_in,
                                                   ch_req, irq_req, flag_done, flag_busy};
                iog_pkg::EVT_OFFS:    prdata_o <= {28'h0, event_reg};
                iog_pkg::EVMASK_OFFS: prdata_o <= {28'h0, evmask_reg};
                default:              prdata_o <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // function decoder
    // ----------------------------------------------------------------
    logic [15:0] pulses;

    iog_fn_decode #(
        .CODE_W     (4)
    ) u_dec (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .code_i     (fcode),
        .strobe_n_i (strobe_n),
        .enable_i   (dec_en_reg),
        .pulse_o    (pulses)
    );

    // idle code pulse goes out alone, nothing else reacts
    assign control_pulse_o = pulses;

    logic io_reset_pulse;
    logic mask_load_pulse;
    // io reset follows controller reset command decode
    assign io_reset_pulse  = pulses[iog_pkg::FC_IO_RESET_PULSE];
    assign mask_load_pulse = pulses[iog_pkg::FC_MASK_LOAD_PULSE];

    // ----------------------------------------------------------------
    // busy/done and requests
    // ----------------------------------------------------------------
    // set requests to flag pins, flag states back out
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_set_n_o <= 1'b1;
            done_set_n_o <= 1'b1;
            busy_o       <= 1'b0;
            done_o       <= 1'b0;
        end else begin
            busy_set_n_o <= ~req_busy;
            done_set_n_o <= ~req_done;
            busy_o       <= flag_busy;
            done_o       <= flag_done;
        end
    end

    // chain in high only without request above
    // chain out feeds the next lower peripheral
    // chain out low when requesting or chain in low
    assign irq_priority_chain_out_o     = irq_chain_in && !irq_req;
    // channel chain gated the same way
    assign channel_priority_chain_out_o = ch_chain_in && !ch_req;
    // answer acknowledges only with chain priority
    assign irq_ack_enable_o             = irq_chain_in && irq_req;
    assign channel_ack_enable_o         = ch_chain_in && ch_req;
    assign bus_irq_request_oe_o         = irq_req;
    assign bus_channel_request_oe_o     = ch_req;

    // ----------------------------------------------------------------
    // jumper data drivers
    // ----------------------------------------------------------------
    // drivers only ever pull low; the wire's pull-up supplies the ones
    assign data_o = 16'h0;

    // jumper code on upper lines during io reset
    // mask bit line pulled low during mask-out
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_oe_o <= 16'h0;
        end else if (io_reset_pulse) begin
            data_oe_o <= {~code_reg, 8'h0};
        end else if (mask_load_pulse) begin
            data_oe_o <= 16'h1 << mbit_reg;
        end else begin
            data_oe_o <= 16'h0;
        end
    end

    // ----------------------------------------------------------------
    // events and interrupt
    // ----------------------------------------------------------------
    logic done_q;
    logic grant_q;
    logic [EV_W-1:0] ev_set;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q  <= 1'b0;
            grant_q <= 1'b0;
        end else begin
            done_q  <= flag_done;
            grant_q <= irq_ack_enable_o;
        end
    end

    always_comb begin
        ev_set                        = '0;
        ev_set[iog_pkg::EV_IO_RESET_PULSE]     = io_reset_pulse;
        ev_set[iog_pkg::EV_MASK]      = mask_load_pulse;
        ev_set[iog_pkg::EV_DONE]      = flag_done && !done_q;
        ev_set[iog_pkg::EV_IRQ_GRANT] = irq_ack_enable_o && !grant_q;
        event_next                    = event_reg;
        // clear only what the read returned: a bit set at the setup edge
        // was not in the read data and must survive the access edge
        if (rd_en && paddr_i == iog_pkg::EVT_OFFS) begin
            event_next = event_reg & ~prdata_o[EV_W-1:0];
        end
        event_next = event_next | ev_set;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_reg <= '0;
            irq_o     <= 1'b0;
        end else begin
            event_reg <= event_next;
            irq_o     <= |(event_next & evmask_reg);
        end
    end

    // ----------------------------------------------------------------
    // phase clock drive
    // ----------------------------------------------------------------
    iog_phase_clk u_clk (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .phase_one_o (clock_phase_one_o),
        .phase_two_o (clock_phase_two_o)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    decode_onehot_a: assert property ($onehot0(control_pulse_o))
        else $error("more than one control pulse");
    strobe_gate_a: assert property ($past(strobe_n) |-> control_pulse_o == 16'h0)
        else $error("pulse without strobe");
    decode_map_a: assert property (!strobe_n && dec_en_reg
                                   |=> control_pulse_o[$past(fcode)])
        else $error("wrong decode");
    phase_sep_a: assert property (!(clock_phase_one_o && clock_phase_two_o))
        else $error("phases overlap");
    irq_chain_a: assert property (irq_priority_chain_out_o ==
        ($past(irq_priority_chain_in_i, 2) && $past(irq_request_sync_n_i, 2)))
        else $error("irq chain out wrong");
    ch_chain_a: assert property (!ch_chain_in |-> !channel_priority_chain_out_o
                                 && !channel_ack_enable_o)
        else $error("channel chain out wrong");
    ack_gate_a: assert property (irq_ack_enable_o |-> irq_chain_in)
        else $error("ack without priority");
    io_reset_drive_a: assert property (io_reset_pulse |=> data_oe_o == {~code_reg, 8'h0})
        else $error("jumper code not driven");
    mask_drive_a: assert property (mask_load_pulse |=> $onehot(data_oe_o)
                                   && data_oe_o[mbit_reg])
        else $error("mask line not driven");
    busy_path_a: assert property (req_busy |=> !busy_set_n_o ##0 $past(flag_busy) == busy_o)
        else $error("busy path wrong");
    io_reset_pulse_event_a: assert property (io_reset_pulse |=> event_reg[iog_pkg::EV_IO_RESET_PULSE])
        else $error("io reset event lost");

    ch_chain_path_a: assert property (channel_priority_chain_out_o ==
        ($past(channel_priority_chain_in_i, 2) && $past(channel_request_sync_n_i, 2)))
        else $error("channel chain path wrong");
    bus_irq_req_a: assert property (bus_irq_request_oe_o ==
        !$past(irq_request_sync_n_i, 2))
        else $error("irq bus request wrong");
    bus_ch_req_a: assert property (bus_channel_request_oe_o ==
        !$past(channel_request_sync_n_i, 2))
        else $error("channel bus request wrong");
    done_path_a: assert property (req_done |=> !done_set_n_o ##0 $past(flag_done) == done_o)
        else $error("done path wrong");
    phase_order_a: assert property (clock_phase_one_o |=> !clock_phase_two_o ##1 clock_phase_two_o)
        else $error("phase order wrong");
    mask_event_a: assert property (mask_load_pulse |=> event_reg[iog_pkg::EV_MASK])
        else $error("mask event lost");
    decode_stand_a: assert property ((!strobe_n && dec_en_reg) ##1
        (!strobe_n && dec_en_reg && $stable(fcode)) |=> $stable(control_pulse_o))
        else $error("pulse not held");
    drivers_idle_a: assert property (!$past(io_reset_pulse) && !$past(mask_load_pulse)
        |-> data_oe_o == 16'h0)
        else $error("data driver left on");
    done_event_a: assert property (flag_done && !done_q |=> event_reg[iog_pkg::EV_DONE])
        else $error("done event lost");
    grant_event_a: assert property (irq_ack_enable_o && !grant_q
        |=> event_reg[iog_pkg::EV_IRQ_GRANT])
        else $error("grant event lost");
    irq_level_a: assert property (irq_o == |(event_reg & $past(evmask_reg)))
        else $error("irq level wrong");
endmodule

/* iog_periph_model.sv */
`timescale 1ns/1ps
module iog_periph_model (
    // clock
    input  wire logic       clock_i,
    // scenario command from the bench
    input  wire logic [5:0] cmd_i,
    // pins seen by the glue
    output logic            irq_chain_in_o,
    output logic            channel_chain_in_o,
    output logic            irq_req_n_o,
    output logic            channel_req_n_o,
    output logic            set_busy_o,
    output logic            set_done_o
);
    // ------------------------------------------------------------
    // neighbour above and own peripheral logic
    // ------------------------------------------------------------
    // the neighbour above sits at the head of the chain, so its own input is high
    initial begin
        irq_chain_in_o     = 1'b1;
        channel_chain_in_o = 1'b1;
        irq_req_n_o        = 1'b1;
        channel_req_n_o    = 1'b1;
        set_busy_o         = 1'b0;
        set_done_o         = 1'b0;
    end
    always @(posedge clock_i) begin
        irq_chain_in_o     <= ~cmd_i[0];
        channel_chain_in_o <= ~cmd_i[2];
        irq_req_n_o        <= ~cmd_i[1];
        channel_req_n_o    <= ~cmd_i[3];
        set_busy_o         <= cmd_i[4];
        set_done_o         <= cmd_i[5];
    end
endmodule

/* iog_phase_clk.sv */
`timescale 1ns/1ps
module iog_phase_clk (
    // clock and reset
    input  wire logic   clock_i,
    input  wire logic   rst_n_i,
    // phase outputs
    output logic        phase_one_o,
    output logic        phase_two_o
);
    // a dead slot between phases keeps them from ever overlapping
    logic [1:0] slot_reg;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot_reg <= 2'h0;
        end else begin
            slot_reg <= slot_reg + 2'h1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_one_o <= 1'b0;
            phase_two_o <= 1'b0;
        end else begin
            phase_one_o <= (slot_reg == 2'h3);
            phase_two_o <= (slot_reg == 2'h1);
        end
    end
endmodule

/* iog_pkg.sv */
package iog_pkg;
    // apb register map
    localparam logic [7:0]  CFG_OFFS      = 8'h00;
    localparam logic [7:0]  STAT_OFFS     = 8'h04;
    localparam logic [7:0]  EVT_OFFS      = 8'h08;
    localparam logic [7:0]  EVMASK_OFFS   = 8'h0c;
    // config fields
    localparam int          CFG_CODE_LSB  = 0;
    localparam int          CFG_MBIT_LSB  = 8;
    localparam int          CFG_DEC_EN    = 12;
    localparam logic [7:0]  CODE_RST      = 8'hff;
    localparam logic [3:0]  MBIT_RST      = 4'h0;
    localparam logic        DEC_EN_RST    = 1'b1;
    localparam logic [3:0]  EVMASK_RST    = 4'h0;
    // event bits
    localparam int          EV_IO_RESET_PULSE      = 0;
    localparam int          EV_MASK       = 1;
    localparam int          EV_DONE       = 2;
    localparam int          EV_IRQ_GRANT  = 3;
    localparam int          EV_W          = 4;
    // function codes
    localparam logic [3:0]  FC_IO_RESET_PULSE      = 4'h9;
    localparam logic [3:0]  FC_MASK_LOAD_PULSE       = 4'ha;
    localparam logic [3:0]  FC_NOP        = 4'hf;
    // two-phase clock: one phase period in system clocks
    localparam int          PHASE_CYC     = 1;
endpackage

/* test_io_controller_peripheral_glue.sv */
`timescale 1ns/1ps
module test_io_controller_peripheral_glue;
    typedef struct { int src; logic [32:0] exp; string what; } iog_note_s;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clock_i = 1'b0, rst_n_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic        pready_o, pslverr_o, irq_o;
    logic [3:0]  function_code_i = 4'h0;
    logic        function_code_valid_n_i = 1'b1, ctl_busy_i = 1'b0, ctl_done_i = 1'b0;
    logic        busy_set_n_o, done_set_n_o, irq_ack_enable_o, channel_ack_enable_o;
    logic        clock_phase_one_o, clock_phase_two_o, busy_o, done_o;
    logic        bus_irq_request_oe_o, bus_channel_request_oe_o;
    logic        set_busy_i, set_done_i, irq_request_sync_n_i, channel_request_sync_n_i;
    logic [15:0] control_pulse_o, data_oe_o, data_o;
    logic [15:0] data_i = 16'h0;
    logic        irq_priority_chain_in_i, irq_priority_chain_out_o;
    logic        channel_priority_chain_in_i, channel_priority_chain_out_o;
    logic [5:0]  cmd = 6'h0;
    iog_note_s   notes[$];
    int          num_errors = 0, total_checks = 0, overlap = 0, multi_hot = 0;
    logic [1:0]  ph_seen = 2'b00;
    logic [7:0]  code;
    logic [3:0]  mbit;
    logic [31:0] r;

    always #5 clock_i = ~clock_i;

    iog_glue uut (.clock_i, .rst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .irq_o, .function_code_i, .function_code_valid_n_i,
        .ctl_busy_i, .ctl_done_i, .busy_set_n_o, .done_set_n_o, .irq_ack_enable_o,
        .channel_ack_enable_o, .clock_phase_one_o, .clock_phase_two_o,
        .bus_irq_request_oe_o, .bus_channel_request_oe_o, .set_busy_i, .set_done_i,
        .busy_o, .done_o, .irq_request_sync_n_i, .channel_request_sync_n_i, .control_pulse_o,
        .data_i, .data_o, .data_oe_o, .irq_priority_chain_in_i, .irq_priority_chain_out_o,
        .channel_priority_chain_in_i, .channel_priority_chain_out_o);

    iog_periph_model peer (.clock_i, .cmd_i(cmd), .irq_chain_in_o(irq_priority_chain_in_i),
        .channel_chain_in_o(channel_priority_chain_in_i), .irq_req_n_o(irq_request_sync_n_i),
        .channel_req_n_o(channel_request_sync_n_i), .set_busy_o(set_busy_i),
        .set_done_o(set_done_i));

    // ------------------------------------------------------------
    // monitor: compares the oldest note when its result appears
    // ------------------------------------------------------------
    function automatic logic [32:0] observe(input int src);
        case (src)
            1: return {17'h0, control_pulse_o};
            2: return {1'b0, data_o, data_oe_o};
            3: return {23'h0, bus_irq_request_oe_o, bus_channel_request_oe_o,
                       irq_priority_chain_out_o, channel_priority_chain_out_o,
                       irq_ack_enable_o, channel_ack_enable_o, busy_o, done_o,
                       busy_set_n_o, done_set_n_o};
            5: return {32'h0, irq_o};
            default: return {1'b0, 16'(overlap), 14'(multi_hot), ph_seen};
        endcase
    endfunction

    task automatic compare(input logic [32:0] got);
        iog_note_s n;
        n = notes.pop_front();
        total_checks++;
        if (got !== n.exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n.what, n.exp, got);
        end
    endtask

    always @(negedge clock_i) begin
        if ($countones(control_pulse_o) > 1) multi_hot++;
        if (clock_phase_one_o && clock_phase_two_o) overlap++;
        ph_seen |= {clock_phase_one_o, clock_phase_two_o};
        while (notes.size() > 0 && notes[0].src != 0) compare(observe(notes[0].src));
    end

    always @(posedge clock_i) begin
        if (psel_i && penable_i && pready_o && !pwrite_i && notes.size() > 0
            && notes[0].src == 0) compare({pslverr_o, prdata_o});
    end

    // ------------------------------------------------------------
    // driver tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e, input string w);
        int n;
        if (!wr) notes.push_back('{0, e, w});
        @(posedge clock_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            wrap_up();
        end
    endtask

    task automatic expect_pin(input int src, input logic [32:0] e, input string w);
        notes.push_back('{src, e, w});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic wrap_up();
        // a note never answered is a missed result
        if (notes.size() != 0) num_errors++;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #100us;
        num_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hdd63d52a));
        settle(16);
        rst_n_i <= 1'b1;
        apb(1'b0, iog_pkg::CFG_OFFS, 32'h0, {20'h0, iog_pkg::DEC_EN_RST, iog_pkg::MBIT_RST,
            iog_pkg::CODE_RST}, "cfg reset");
        apb(1'b0, iog_pkg::EVMASK_OFFS, 32'h0, {29'h0, iog_pkg::EVMASK_RST}, "mask reset");
        apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0}, "unmapped read");
        $display("test registers done");
        r = $urandom;
        code = r[7:0];
        mbit = r[11:8];
        apb(1'b1, iog_pkg::CFG_OFFS, {19'h0, 1'b1, mbit, code}, 33'h0, "");
        apb(1'b1, iog_pkg::EVMASK_OFFS, 32'h1, 33'h0, "");
        for (int i = 0; i < 16; i++) begin
            function_code_i <= 4'(i);
            function_code_valid_n_i <= 1'b0;
            settle(3);
            expect_pin(1, 33'h1 << i, "pulse on");
            settle(1);
            if (i == 9) expect_pin(2, {17'h0, ~code, 8'h00}, "reset drivers");
            if (i == 10) expect_pin(2, 33'h1 << mbit, "mask driver");
            function_code_valid_n_i <= 1'b1;
            function_code_i <= 4'($urandom);
            settle(4);
            expect_pin(1, 33'h0, "strobe high");
        end
        apb(1'b1, iog_pkg::CFG_OFFS, {19'h0, 1'b0, mbit, code}, 33'h0, "");
        function_code_valid_n_i <= 1'b0;
        settle(4);
        expect_pin(1, 33'h0, "decode disabled");
        function_code_valid_n_i <= 1'b1;
        settle(4);
        apb(1'b1, iog_pkg::CFG_OFFS, {19'h0, 1'b1, mbit, code}, 33'h0, "");
        $display("test decode done");
        settle(2);
        expect_pin(5, 33'h1, "irq raised");
        apb(1'b1, iog_pkg::EVMASK_OFFS, 32'h2, 33'h0, "");
        settle(2);
        expect_pin(5, 33'h1, "irq other bit");
        apb(1'b1, iog_pkg::EVMASK_OFFS, 32'h4, 33'h0, "");
        settle(2);
        expect_pin(5, 33'h0, "irq masked");
        apb(1'b0, iog_pkg::EVT_OFFS, 32'h0, 33'h3, "events");
        apb(1'b1, iog_pkg::EVMASK_OFFS, 32'h3, 33'h0, "");
        settle(2);
        expect_pin(5, 33'h0, "irq cleared");
        apb(1'b0, iog_pkg::EVT_OFFS, 32'h0, 33'h0, "events cleared");
        $display("test interrupt done");
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            cmd <= r[5:0];
            ctl_busy_i <= r[6];
            ctl_done_i <= r[7];
            settle(5);
            expect_pin(3, {23'h0, r[1], r[3], ~r[0] & ~r[1], ~r[2] & ~r[3],
                r[1] & ~r[0], r[3] & ~r[2], r[6], r[7], ~r[4], ~r[5]},
                "chains and flags");
        end
        apb(1'b0, iog_pkg::STAT_OFFS, 32'h0, {23'h0, function_code_i, ~r[2], ~r[0], r[3], r[1],
            r[7], r[6]}, "status");
        $display("test chains done");
        settle(2);
        expect_pin(4, {1'b0, 16'h0, 14'h0, 2'b11}, "phase and one-hot");
        settle(2);
        $display("test phase done");
        wrap_up();
    end
endmodule
